// ### hdl/remap_config_lock_guard.sv
// remap_config_lock_guard: lock, key sequence, one-shot option, shadowed select banks
// and the pin/peripheral routing they steer
// assumes pins arrive unsynchronised; peripheral outputs and analog settings share the clock
`timescale 1ns/1ns
`default_nettype none
module remap_config_lock_guard #(
    parameter int N_IN_REGS = remap_pkg::N_IN_REGS,
    parameter int N_OUT_REGS = remap_pkg::N_OUT_REGS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] package_variant_i,
    input wire logic [7:0] osc_config_word_i,
    input wire logic osc_wr_i,
    input wire logic [7:0] osc_wdata_i,
    input wire logic sel_wr_i,
    input wire logic sel_output_i,
    input wire logic [4:0] sel_index_i,
    input wire logic [15:0] sel_wdata_i,
    input wire logic [remap_pkg::N_PINS-1:0] remap_io_pin_i,
    input wire logic [remap_pkg::N_PINS-1:0] pin_analog_i,
    input wire logic [31:0] periph_out_i,
    output logic [2*N_IN_REGS-1:0] periph_in_o,
    output logic [remap_pkg::N_IO_PINS-1:0] pin_out_o,
    output logic [remap_pkg::N_IO_PINS-1:0] pin_out_en_o,
    output logic remap_write_lock_o,
    output logic cfg_mismatch_rst_o
);
    localparam int N_IN_FUNCS = 2 * N_IN_REGS;
    localparam int N_IO = remap_pkg::N_IO_PINS;

    // refuse sizes the 5-bit index or the pin set cannot serve
    if (N_IN_REGS < 1 || N_IN_REGS > 32) begin : g_chk_in
        $error("N_IN_REGS must lie in 1..32");
    end
    if (2 * N_OUT_REGS < N_IO || N_OUT_REGS > 32) begin : g_chk_out
        $error("N_OUT_REGS must cover every I/O pin and fit the index");
    end

    // pin and strap synchronisers
    logic [remap_pkg::N_PINS-1:0] pin_meta;
    logic [remap_pkg::N_PINS-1:0] pin_sync;
    logic [1:0] variant_meta;
    logic [1:0] variant_sync;
    logic one_shot_meta;
    logic one_shot_sync;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            variant_meta <= remap_pkg::VAR_FULL;
            variant_sync <= remap_pkg::VAR_FULL;
            one_shot_meta <= remap_pkg::ONE_SHOT_DEFAULT;
            one_shot_sync <= remap_pkg::ONE_SHOT_DEFAULT;
        end else begin
            pin_meta <= remap_io_pin_i;
            pin_sync <= pin_meta;
            variant_meta <= package_variant_i;
            variant_sync <= variant_meta;
            one_shot_meta <= osc_config_word_i[remap_pkg::ONE_SHOT_BIT];
            one_shot_sync <= one_shot_meta;
        end
    end

    // key sequence and lock state
    remap_pkg::key_state_t key_state;
    remap_pkg::key_state_t next_key_state;
    logic remap_write_lock;
    logic next_lock;

    always_comb begin
        next_key_state = key_state;
        next_lock = remap_write_lock;
        if (osc_wr_i) begin
            case (key_state)
                remap_pkg::KEY_IDLE: begin
                    if (osc_wdata_i == remap_pkg::KEY_FIRST) begin
                        next_key_state = remap_pkg::KEY_GOT_FIRST;
                    end
                end
                remap_pkg::KEY_GOT_FIRST: begin
                    if (osc_wdata_i == remap_pkg::KEY_SECOND) begin
                        next_key_state = remap_pkg::KEY_GOT_SECOND;
                    end else if (osc_wdata_i == remap_pkg::KEY_FIRST) begin
                        next_key_state = remap_pkg::KEY_GOT_FIRST;
                    end else begin
                        next_key_state = remap_pkg::KEY_IDLE;
                    end
                end
                remap_pkg::KEY_GOT_SECOND: begin
                    next_key_state = remap_pkg::KEY_IDLE;
                    // one-shot mode refuses only a clear of an already set lock
                    if (osc_wdata_i[remap_pkg::LOCK_BIT] ||
                        !(one_shot_sync && remap_write_lock)) begin
                        next_lock = osc_wdata_i[remap_pkg::LOCK_BIT];
                    end
                end
                default: begin
                    next_key_state = remap_pkg::KEY_IDLE;
                end
            endcase
        end else if (sel_wr_i) begin
            next_key_state = remap_pkg::KEY_IDLE;
        end
    end

    // lock holds between sequences; only reset clears it unconditionally
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_state <= remap_pkg::KEY_IDLE;
            remap_write_lock <= remap_pkg::LOCK_RST;
        end else begin
            key_state <= next_key_state;
            remap_write_lock <= next_lock;
        end
    end

    // qualify select writes: lock gates both banks, absent pins mask output fields
    logic in_wr;
    logic out_wr;
    logic [15:0] out_mask;
    logic [5:0] pin_lo;
    logic [5:0] pin_hi;

    always_comb begin
        in_wr = sel_wr_i && !sel_output_i && !remap_write_lock;
        out_wr = sel_wr_i && sel_output_i && !remap_write_lock;
        pin_lo = {sel_index_i, 1'b0};
        pin_hi = {sel_index_i, 1'b1};
        out_mask = 16'h0000;
        if (pin_lo < 6'(N_IO) && remap_pkg::pin_present(variant_sync, pin_lo)) begin
            out_mask = out_mask | remap_pkg::FIELD0_MASK;
        end
        if (pin_hi < 6'(N_IO) && remap_pkg::pin_present(variant_sync, pin_hi)) begin
            out_mask = out_mask | remap_pkg::FIELD1_MASK;
        end
    end

    logic [N_IN_REGS*16-1:0] in_flat;
    logic [N_OUT_REGS*16-1:0] out_flat;
    logic in_mismatch;
    logic out_mismatch;

    // input-select bank, reset to all-ones codes
    remap_select_bank #(
        .N_REGS(N_IN_REGS),
        .RST_VAL(remap_pkg::IN_SEL_RST)
    ) u_in_bank (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(in_wr),
        .idx_i(sel_index_i),
        .wdata_i(sel_wdata_i),
        .wmask_i(remap_pkg::FIELD_MASK),
        .regs_o(in_flat),
        .mismatch_o(in_mismatch)
    );

    // output-select bank, reset to the null output
    remap_select_bank #(
        .N_REGS(N_OUT_REGS),
        .RST_VAL(remap_pkg::OUT_SEL_RST)
    ) u_out_bank (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(out_wr),
        .idx_i(sel_index_i),
        .wdata_i(sel_wdata_i),
        .wmask_i(out_mask),
        .regs_o(out_flat),
        .mismatch_o(out_mismatch)
    );

    // routing: one code per input and per pin, so no two drivers can meet
    logic [N_IN_FUNCS-1:0] next_periph_in;
    logic [N_IO-1:0] next_pin_out;
    logic [N_IO-1:0] next_pin_en;
    logic next_mismatch;

    always_comb begin
        logic [5:0] code;
        code = 6'h00;
        for (int f = 0; f < N_IN_FUNCS; f++) begin
            code = in_flat[f*remap_pkg::FIELD_STRIDE +: remap_pkg::FIELD_W];
            next_periph_in[f] = 1'b0;
            if (remap_pkg::pin_present(variant_sync, code)) begin
                next_periph_in[f] = pin_sync[code] && !pin_analog_i[code];
            end
        end
        for (int p = 0; p < N_IO; p++) begin
            code = out_flat[p*remap_pkg::FIELD_STRIDE +: remap_pkg::FIELD_W];
            // routes the selected output and enables the pin driver for any code other than null, below 20h, on a non-analog pin
            next_pin_en[p] = code != remap_pkg::NULL_OUTPUT &&
                code < remap_pkg::OUT_CODE_LIMIT && !pin_analog_i[p];
            next_pin_out[p] = next_pin_en[p] && periph_out_i[code[4:0]];
        end
        next_mismatch = cfg_mismatch_rst_o || in_mismatch || out_mismatch;
    end

    // registered outputs; the mismatch request holds until the device resets
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            periph_in_o <= '0;
            pin_out_o <= '0;
            pin_out_en_o <= '0;
            remap_write_lock_o <= remap_pkg::LOCK_RST;
            cfg_mismatch_rst_o <= 1'b0;
        end else begin
            periph_in_o <= next_periph_in;
            pin_out_o <= next_pin_out;
            pin_out_en_o <= next_pin_en;
            remap_write_lock_o <= remap_write_lock;
            cfg_mismatch_rst_o <= next_mismatch;
        end
    end

    // helper: first cycle after reset release
    logic after_rst;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            after_rst <= 1'b0;
        end else begin
            after_rst <= 1'b1;
        end
    end

    // protocol and routing checks, all on the system clock
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // key pair issued back to back, starting from an idle tracker
    sequence s_key_pair;
        osc_wr_i && osc_wdata_i == remap_pkg::KEY_FIRST && key_state == remap_pkg::KEY_IDLE
        ##1 osc_wr_i && osc_wdata_i == remap_pkg::KEY_SECOND;
    endsequence

    // lock-change writes that follow the key pair
    sequence s_clear_write;
        osc_wr_i && !osc_wdata_i[remap_pkg::LOCK_BIT];
    endsequence

    sequence s_set_write;
        osc_wr_i && osc_wdata_i[remap_pkg::LOCK_BIT];
    endsequence

    a_reset_state: assert property (!after_rst |-> !remap_write_lock
        && in_flat == {N_IN_REGS{remap_pkg::IN_SEL_RST}} && out_flat == '0)
        else $error("select banks or lock not at reset values");

    a_key_unlocks: assert property (s_key_pair ##1 s_clear_write ##0 !one_shot_sync
        |=> !remap_write_lock ##1 !remap_write_lock_o)
        else $error("key sequence did not clear the lock");

    a_lock_needs_key: assert property ($changed(remap_write_lock) |->
        $past(key_state) == remap_pkg::KEY_GOT_SECOND && $past(osc_wr_i))
        else $error("lock changed outside the key sequence");

    a_lock_holds: assert property (!osc_wr_i |=> $stable(remap_write_lock))
        else $error("lock moved without a control write");

    a_one_shot_hold: assert property (one_shot_sync && remap_write_lock
        && $stable(one_shot_sync) |=> remap_write_lock)
        else $error("one-shot lock was cleared");

    a_locked_frozen: assert property (remap_write_lock && sel_wr_i
        |=> $stable(in_flat) && $stable(out_flat))
        else $error("select register changed while locked");

    a_absent_field: assert property (2 * N_OUT_REGS > N_IO |->
        out_flat[N_IO*remap_pkg::FIELD_STRIDE +: remap_pkg::FIELD_W] == 6'h00)
        else $error("unimplemented output field took a value");

    a_invalid_ground: assert property (in_flat[5:0] >= remap_pkg::PIN_LIMIT
        |=> !periph_in_o[0])
        else $error("invalid input code routed a pin");

    a_analog_kept: assert property (pin_analog_i[0] |=> !pin_out_en_o[0]
        ##0 !pin_out_o[0])
        else $error("remap drove an analog pin");

    a_mismatch_sticky: assert property ($rose(cfg_mismatch_rst_o) |=>
        cfg_mismatch_rst_o [*4])
        else $error("mismatch reset request dropped");

    a_key_locks: assert property (s_key_pair ##1 s_set_write |=> remap_write_lock
        ##1 remap_write_lock_o)
        else $error("key sequence did not set the lock");

    a_one_shot_refuse: assert property (s_key_pair ##1 s_clear_write
        ##0 one_shot_sync ##0 remap_write_lock |=> remap_write_lock)
        else $error("one-shot lock accepted a clear");

    a_sel_abandons: assert property (sel_wr_i && !osc_wr_i |=>
        key_state == remap_pkg::KEY_IDLE)
        else $error("select write left a key sequence pending");

    a_lock_mirror: assert property (remap_write_lock_o == $past(remap_write_lock))
        else $error("lock output does not follow the lock");

    a_out_gated: assert property ((pin_out_o & ~pin_out_en_o) == '0)
        else $error("pin driven high without its enable");
endmodule
`default_nettype wire

// ### hdl/remap_pkg.sv
// remap_pkg: constants, types and pin-availability decode for the remap lock guard
// assumes a single 250 MHz system clock and an active-low asynchronous device reset
//
// Functional notes
// - input-select code naming an absent pin is invalid; that input routes no pin
// - output-select fields of absent pins are unimplemented; writes change nothing
// - while locked, select writes complete silently but stored contents stay unchanged
// - the lock is bit 6 of the oscillator control register; one blocks, zero permits
// - write 46h, then 57h, then the lock change in one write
// - the lock holds its value until software changes it again
// - shadow copies of all select registers; any divergence raises a mismatch reset
// - with one-shot config bit 5 set, a set lock cannot be cleared
// - under one-shot locking only a device reset clears the lock
// - one-shot config bit reads set when unprogrammed; zero allows unlimited sessions
// - every input-select field resets to all ones, tying inputs to ground
// - every output-select field resets to zero, leaving pins disconnected
// - the lock comes out of reset cleared
// - mapping a peripheral never enables it nor changes other pin configuration
// - a remap selection never overrides a pin configured as analog
// - pin set follows the package variant: 29 I/O plus 4 input-only at most
// - each output-select register holds two 6-bit fields, one per pin
// - contention of inputs or outputs is blocked; fan-out stays allowed
package remap_pkg;
    localparam int REG_W = 16;
    localparam int FIELD_W = 6;
    localparam int FIELD_STRIDE = 8;
    localparam logic [15:0] FIELD_MASK = 16'h3F3F;
    localparam logic [15:0] FIELD0_MASK = 16'h003F;
    localparam logic [15:0] FIELD1_MASK = 16'h3F00;
    localparam logic [15:0] IN_SEL_RST = 16'h3F3F;
    localparam logic [15:0] OUT_SEL_RST = 16'h0000;
    localparam logic [5:0] NULL_OUTPUT = 6'h00;
    localparam logic [5:0] OUT_CODE_LIMIT = 6'h20;
    localparam int N_IO_PINS = 29;
    localparam int N_PINS = 33;
    localparam logic [5:0] PIN_LIMIT = 6'h21;
    localparam logic [5:0] IN_ONLY_FIRST = 6'h1D;
    localparam logic [5:0] SMALL_GAP_LO = 6'h10;
    localparam logic [5:0] SMALL_GAP_HI = 6'h19;
    localparam int N_IN_REGS = 19;
    localparam int N_OUT_REGS = 15;
    localparam int LOCK_BIT = 6;
    localparam int ONE_SHOT_BIT = 5;
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;
    localparam logic LOCK_RST = 1'b0;
    localparam logic ONE_SHOT_DEFAULT = 1'b1;
    localparam logic [1:0] VAR_FULL = 2'h0;
    localparam logic [1:0] VAR_NO_IN_ONLY = 2'h1;
    localparam logic [1:0] VAR_SMALL = 2'h2;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'h0,
        KEY_GOT_FIRST = 2'h1,
        KEY_GOT_SECOND = 2'h3
    } key_state_t;

    // whether a pin number exists on the given package variant
    function automatic logic pin_present(input logic [1:0] variant, input logic [5:0] pin);
        logic ok;
        ok = (pin < PIN_LIMIT);
        if (variant != VAR_FULL && pin >= IN_ONLY_FIRST) begin
            ok = 1'b0;
        end
        if (variant == VAR_SMALL && pin >= SMALL_GAP_LO && pin <= SMALL_GAP_HI) begin
            ok = 1'b0;
        end
        return ok;
    endfunction
endpackage

// ### hdl/remap_select_bank.sv
// remap_select_bank: a bank of select registers with shadow copies and a compare
// assumes writes arrive already qualified by the lock and a per-field write mask
`timescale 1ns/1ns
`default_nettype none
module remap_select_bank #(
    parameter int N_REGS = 19,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_i,
    input wire logic [4:0] idx_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] wmask_i,
    output logic [N_REGS*16-1:0] regs_o,
    output logic mismatch_o
);
    logic [15:0] prim [N_REGS];
    logic [15:0] shadow [N_REGS];
    logic [15:0] next_prim [N_REGS];
    logic [15:0] next_shadow [N_REGS];
    logic next_mismatch;

    // write primary and shadow together, then compare every register
    always_comb begin
        next_prim = prim;
        next_shadow = shadow;
        next_mismatch = 1'b0;
        for (int i = 0; i < N_REGS; i++) begin
            if (wr_i && idx_i == 5'(i)) begin
                next_prim[i] = (prim[i] & ~wmask_i) | (wdata_i & wmask_i);
                next_shadow[i] = (prim[i] & ~wmask_i) | (wdata_i & wmask_i);
            end
            if (prim[i] != shadow[i]) begin
                next_mismatch = 1'b1;
            end
        end
    end

    // register the bank, its shadow and the compare result
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N_REGS; i++) begin
                prim[i] <= RST_VAL;
                shadow[i] <= RST_VAL;
            end
            mismatch_o <= 1'b0;
        end else begin
            prim <= next_prim;
            shadow <= next_shadow;
            mismatch_o <= next_mismatch;
        end
    end

    // flatten the primary copies for the routing logic
    for (genvar g = 0; g < N_REGS; g++) begin : g_flat
        assign regs_o[g*16 +: 16] = prim[g];
    end

    a_shadow_agree: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_i |=> !mismatch_o ##1 !mismatch_o)
        else $error("shadow copy diverged after a legitimate write");
endmodule
`default_nettype wire

// ### verif/remap_far_side.sv
// remap_far_side: package pins and peripheral outputs facing the remap block
// assumes the bench supplies levels each cycle and marks pins absent on the package
`timescale 1ns/1ns
`default_nettype none
module remap_far_side (
    input wire logic sys_clk_i,
    input wire logic [32:0] level_i,
    input wire logic [32:0] absent_i,
    input wire logic [32:0] analog_i,
    input wire logic [31:0] periph_i,
    output logic [32:0] remap_io_pin_o,
    output logic [32:0] pin_analog_o,
    output logic [31:0] periph_out_o
);
    logic [32:0] level = '0;
    logic [32:0] flip = '0;
    // pins and peripherals settle on the clock; absent pins float and toggle each cycle
    always @(posedge sys_clk_i) begin
        flip <= ~flip;
        level <= level_i;
        pin_analog_o <= analog_i;
        periph_out_o <= periph_i;
    end
    assign remap_io_pin_o = (level & ~absent_i) | (flip & absent_i);
endmodule
`default_nettype wire

// ### verif/tb.sv
// tb: remap lock guard against a behavioural model of the select banks and lock
// assumes a 250 MHz clock; strap and pin changes need a few cycles to pass the synchronisers
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] variant = 2'h0;
    logic [7:0] cfg = 8'h20;
    logic osc_wr = 1'b0, sel_wr = 1'b0, sel_out = 1'b0;
    logic [7:0] osc_d = 8'h00;
    logic [4:0] sel_idx = 5'h00;
    logic [15:0] sel_d = 16'h0000;
    logic [32:0] lvl = '0, absent = '0, ana = '0;
    logic [31:0] per = '0, seed = 32'h511F;
    logic [32:0] pins, pana;
    logic [31:0] pout;
    logic [37:0] p_in;
    logic [28:0] p_out, p_en;
    logic lock_q, mism;
    logic [15:0] m_in [19];
    logic [15:0] m_out [15];
    logic m_lock;
    int m_key, failures = 0, n_checks = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    remap_far_side remap_far_side_i (.sys_clk_i(sys_clk_i), .level_i(lvl), .absent_i(absent),
        .analog_i(ana), .periph_i(per), .remap_io_pin_o(pins), .pin_analog_o(pana),
        .periph_out_o(pout));

    remap_config_lock_guard remap_config_lock_guard_i (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .package_variant_i(variant), .osc_config_word_i(cfg),
        .osc_wr_i(osc_wr), .osc_wdata_i(osc_d), .sel_wr_i(sel_wr), .sel_output_i(sel_out),
        .sel_index_i(sel_idx), .sel_wdata_i(sel_d), .remap_io_pin_i(pins),
        .pin_analog_i(pana), .periph_out_i(pout), .periph_in_o(p_in), .pin_out_o(p_out),
        .pin_out_en_o(p_en), .remap_write_lock_o(lock_q), .cfg_mismatch_rst_o(mism));

    // xorshift source for pins, analog settings and write traffic
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // pin exists on the package variant
    function automatic logic present(input logic [1:0] v, input logic [5:0] p);
        return p < 6'h21 && !(v != 2'h0 && p >= 6'h1D)
            && !(v == 2'h2 && p >= 6'h10 && p <= 6'h19);
    endfunction

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic idle();
        step();
        osc_wr = 1'b0;
        sel_wr = 1'b0;
    endtask

    // oscillator control write; the model tracks the key and the lock
    task automatic osc(input logic [7:0] d);
        step();
        osc_wr = 1'b1;
        sel_wr = 1'b0;
        osc_d = d;
        if (m_key == 2) begin
            if (d[6] || !cfg[5] || !m_lock) m_lock = d[6];
            m_key = 0;
        end else if (d == 8'h46) begin
            m_key = 1;
        end else begin
            m_key = (m_key == 1 && d == 8'h57) ? 2 : 0;
        end
    endtask

    // select write; dropped when locked, out of range or on an absent pin
    task automatic sel(input logic o, input logic [4:0] i, input logic [15:0] d);
        int p;
        step();
        sel_wr = 1'b1;
        osc_wr = 1'b0;
        sel_out = o;
        sel_idx = i;
        sel_d = d;
        m_key = 0;
        if (!m_lock && !o && i < 19) m_in[i] = d & 16'h3F3F;
        for (int j = 0; j < 2; j++) begin
            p = 2 * i + j;
            if (!m_lock && o && i < 15 && p < 29 && present(variant, 6'(p))) begin
                m_out[i][8*j +: 6] = d[8*j +: 6];
            end
        end
    endtask

    task automatic fill(input int n);
        logic [31:0] r;
        for (int k = 0; k < n; k++) begin
            r = rnd();
            sel(r[31], r[20:16], r[29] ? r[15:0] : r[15:0] & 16'h1F1F);
        end
        idle();
    endtask

    task automatic shake();
        lvl = 33'({rnd(), rnd()});
        ana = 33'({rnd() & rnd(), rnd() & rnd()});
        per = rnd();
    endtask

    task automatic boot(input logic [1:0] v, input logic [7:0] c);
        rst_n_i = 1'b0;
        variant = v;
        cfg = c;
        for (int p = 0; p < 33; p++) absent[p] = !present(v, 6'(p));
        foreach (m_in[i]) m_in[i] = 16'h3F3F;
        foreach (m_out[i]) m_out[i] = 16'h0000;
        m_lock = 1'b0;
        m_key = 0;
        repeat (12) step();
        rst_n_i = 1'b1;
        repeat (4) step();
    endtask

    // expected routing from the model registers and the far-side levels
    task automatic check(input string nm);
        logic [37:0] ei;
        logic [28:0] eo, ee;
        logic [5:0] c;
        repeat (6) step();
        for (int f = 0; f < 38; f++) begin
            c = m_in[f/2][8*(f%2) +: 6];
            ei[f] = present(variant, c) && lvl[c] && !ana[c];
        end
        for (int p = 0; p < 29; p++) begin
            c = m_out[p/2][8*(p%2) +: 6];
            ee[p] = c != 6'h00 && c < 6'h20 && !ana[p];
            eo[p] = ee[p] & per[c[4:0]];
        end
        cmp("periph_in", 64'(p_in), 64'(ei));
        cmp("pin_out_en", 64'(p_en), 64'(ee));
        cmp("pin_out", 64'(p_out), 64'(eo));
        cmp("lock", 64'(lock_q), 64'(m_lock));
        cmp("mismatch", 64'(mism), 64'h0);
        $display("test %s done", nm);
    endtask

    initial begin
        repeat (50000) @(posedge sys_clk_i);
        failures++;
        $display("Error run time expected end seen none");
        wrap_up();
    end

    initial begin
        boot(2'h0, 8'h20);
        check("reset");
        shake();
        fill(80);
        check("unlocked writes");
        osc(8'h46);
        osc(8'h57);
        osc(8'h40);
        idle();
        check("lock set");
        fill(30);
        check("locked writes");
        osc(8'h46);
        osc(8'h57);
        osc(8'h00);
        idle();
        check("one shot");
        boot(2'h0, 8'h00);
        check("reset unlocks");
        osc(8'h46);
        idle();
        osc(8'h57);
        idle();
        osc(8'h40);
        osc(8'h46);
        osc(8'h57);
        osc(8'h00);
        fill(20);
        check("unlimited sessions");
        osc(8'h46);
        sel(1'b0, 5'h00, 16'h0102);
        osc(8'h57);
        osc(8'h40);
        idle();
        check("broken key");
        for (int k = 0; k < 12; k++) osc(k[0] ? 8'h57 : 8'(rnd()) | 8'h06);
        fill(20);
        check("random keys");
        for (int v = 0; v < 4; v++) begin
            boot(2'(v), 8'h20);
            shake();
            fill(80);
            check("variant");
        end
        wrap_up();
    end
endmodule
`default_nettype wire
